/* speed_judge_defs.svh */
// Register map, field positions and timing constants of the speed limit judge.
// Overview of operation
// - Auto mode output follows comparison each update.
// - Auto mode hysteresis separates on and off thresholds.
// - Hysteresis spans twenty percent, auto mode only.
// - High limit on at value; low below.
// - Latched mode output holds once condition true.
// - Panel or external reset clears latched output.
// - Armed or running section blocks latch reset until idle.
// - One-shot output lasts exactly the pulse width.
// - Pulse width 10 to 2000 ms, 10 ms.
// - Delay needs condition unbroken; lapse restarts timing.
// - Delay applies in all three output modes.
// - Delay 0 to 1000 ms in 50 ms.
// - Normal channel closes while system runs normally.
// - Normal channel opens when another judging channel acts.
// - Error channel closes on errors, not serial ones.
// - Errors include bad input and bad setup.
// - Section runs once start to stop, then halts.
// - Manual section accumulates from start to stop press.
// - Auto section start press only arms measurement.
// - Armed section starts on condition, stops on duration.
// - Threshold start triggers approaching from either side.
// - Section computes average, maximum and minimum.
// - Two-line display shows live value and statistic.
// - Section maximum display refreshes once per second.
`ifndef SPEED_JUDGE_DEFS_SVH
`define SPEED_JUDGE_DEFS_SVH
`define CLK_NS      5
`define TICK_NS     10_000_000
`define SEC_NS      1_000_000_000
`define TICK_MS     10
`define DLY_STEP_MS 50
`define PW_STEP_MS  10
`define DLY_TICKS   (`DLY_STEP_MS / `TICK_MS)
`define PW_TICKS    (`PW_STEP_MS / `TICK_MS)
`define PW_MIN      8'h01
`define PW_MAX      8'hc8
`define DLY_MAX     5'h14
`define HYST_MAX    6'sh14
`define PCT         100
`define LIMIT_MAX   20'hf_423f
`define CFG_W       23
`define REG_CTRL    8'h00
`define REG_THR     8'h04
`define REG_SECS    8'h08
`define REG_STAT    8'h0c
`define REG_AVG     8'h10
`define REG_MAX     8'h14
`define REG_MIN     8'h18
`define REG_CH      8'h20
`define CH_STRIDE   8'h10
`define CH_LIMIT    8'h04
`define CTRL_SS     0
`define CTRL_AUTO   1
`define CTRL_2L     2
`define CTRL_SEL    3
`endif

/* speed_judge_pkg.sv */
// Types shared by the speed limit judge.
package speed_judge_pkg;
  typedef enum logic [1:0] {F_UPPER, F_LOWER, F_OK, F_ERROR} func_e;
  typedef enum logic [1:0] {M_AUTO, M_LATCH, M_PULSE} mode_e;
  typedef enum logic [1:0] {S_IDLE, S_ARMED, S_RUN} sect_e;
  typedef struct packed {
    func_e             func;
    mode_e             mode;
    logic signed [5:0] hyst;
    logic [7:0]        pw;
    logic [4:0]        dly;
  } ch_cfg_s;
  typedef struct packed {
    logic [19:0] avg;
    logic [19:0] max;
    logic [19:0] min;
  } sect_stat_s;
endpackage

/* speed_limit_judge.sv */
// Limit judgment, relay drive and start/stop section statistics.
`timescale 1ns/1ps
`include "speed_judge_defs.svh"
module speed_limit_judge
#(
  parameter int VAL_W    = 20,
  parameter int NCH      = 3,
  parameter int TICK_CYC = `TICK_NS / `CLK_NS,
  parameter int SEC_CYC  = `SEC_NS / `CLK_NS
)
(
  // Clock, reset and enable.
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 ce,
  // Register port.
  input  wire logic [7:0]           addr,
  input  wire logic [31:0]          wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [31:0]          rdata_q,
  // Measurement from the arithmetic.
  input  wire logic [VAL_W-1:0]     meas_value,
  input  wire logic                 meas_valid,
  input  wire logic                 meas_err,
  // Panel switches and external reset pin.
  input  wire logic                 start_sw,
  input  wire logic                 stop_sw,
  input  wire logic                 reset_sw,
  input  wire logic                 ext_reset,
  // Relays and displays.
  output logic      [NCH-1:0]       relay_q,
  output logic      [VAL_W-1:0]     main_disp_q,
  output logic      [VAL_W-1:0]     sub_disp_q,
  output logic                      ss_busy_q
);
  import speed_judge_pkg::*;

  function automatic logic judge(ch_cfg_s c, logic [VAL_W-1:0] lim,
                                 logic [VAL_W-1:0] v, logic hold);
    int adj;
    adj = int'(lim) * int'(c.hyst) / `PCT;
    unique case (c.func)
      F_UPPER: judge = hold ? (int'(v) >= int'(lim) - adj) : (v >= lim);
      F_LOWER: judge = hold ? (int'(v) < int'(lim) + adj) : (v < lim);
      default: judge = 1'b0;
    endcase
  endfunction

  function automatic logic [6:0] need_ticks(logic [4:0] dly);
    need_ticks = 7'(dly * `DLY_TICKS);
  endfunction

  function automatic logic cfg_bad(ch_cfg_s c, logic [VAL_W-1:0] lim);
    cfg_bad = (c.mode == 2'b11) || (c.hyst > `HYST_MAX) || (c.hyst < -`HYST_MAX)
      || (c.dly > `DLY_MAX) || (lim > `LIMIT_MAX)
      || (c.mode == M_PULSE && (c.pw < `PW_MIN || c.pw > `PW_MAX));
  endfunction

  // Pin synchronisers: start, stop, panel reset, external reset.
  logic [3:0] sync1_q, sync2_q, prev_q;
  always_ff @(posedge clk)
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end
    else if (ce)
    begin
      sync1_q <= {ext_reset, reset_sw, stop_sw, start_sw};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  logic start_e, stop_e, reset_lvl;
  assign start_e   = sync2_q[0] & ~prev_q[0];
  assign stop_e    = sync2_q[1] & ~prev_q[1];
  assign reset_lvl = sync2_q[2] | sync2_q[3];

  // Configuration registers.
  logic [4:0]       ctrl_q;
  logic [VAL_W-1:0] thr_q;
  logic [15:0]      secs_lim_q;
  ch_cfg_s          cfg_q [NCH];
  logic [VAL_W-1:0] lim_q [NCH];
  always_ff @(posedge clk)
    if (rst)
    begin
      ctrl_q     <= '0;
      thr_q      <= '0;
      secs_lim_q <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        cfg_q[i] <= '0;
        lim_q[i] <= '0;
      end
    end
    else if (ce && wr)
    begin
      if (addr == `REG_CTRL) ctrl_q <= wdata[4:0];
      if (addr == `REG_THR) thr_q <= wdata[VAL_W-1:0];
      if (addr == `REG_SECS) secs_lim_q <= wdata[15:0];
      for (int i = 0; i < NCH; i++)
      begin
        if (addr == 8'(`REG_CH + i * `CH_STRIDE)) cfg_q[i] <= ch_cfg_s'(wdata[`CFG_W-1:0]);
        if (addr == 8'(`REG_CH + i * `CH_STRIDE + `CH_LIMIT)) lim_q[i] <= wdata[VAL_W-1:0];
      end
    end

  // Output update tick.
  logic [31:0] tick_cnt_q;
  logic        tick;
  assign tick = (tick_cnt_q == 32'(TICK_CYC - 1));
  always_ff @(posedge clk)
    if (rst) tick_cnt_q <= '0;
    else if (ce) tick_cnt_q <= tick ? '0 : tick_cnt_q + 32'h0000_0001;

  // Section state is declared here because latch reset depends on it.
  sect_e st_q;
  logic  clr;
  assign clr = reset_lvl && !(ctrl_q[`CTRL_SS] && st_q != S_IDLE);

  // Judgment channels.
  logic [NCH-1:0] act_q, qprev_q, cond, qual, bad;
  logic [6:0]     dcnt_q [NCH];
  logic [7:0]     pcnt_q [NCH];
  always_comb
    for (int i = 0; i < NCH; i++)
    begin
      cond[i] = judge(cfg_q[i], lim_q[i], meas_value,
                      act_q[i] && cfg_q[i].mode == M_AUTO);
      qual[i] = cond[i] && (dcnt_q[i] >= need_ticks(cfg_q[i].dly));
      bad[i]  = cfg_bad(cfg_q[i], lim_q[i]);
    end

  always_ff @(posedge clk)
    if (rst)
    begin
      act_q   <= '0;
      qprev_q <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        dcnt_q[i] <= '0;
        pcnt_q[i] <= '0;
      end
    end
    else if (ce)
      for (int i = 0; i < NCH; i++)
      begin
        if (tick)
        begin
          dcnt_q[i]  <= !cond[i] ? '0 : qual[i] ? dcnt_q[i] : dcnt_q[i] + 7'h01;
          qprev_q[i] <= qual[i];
        end
        unique case (cfg_q[i].mode)
          M_AUTO:  if (tick) act_q[i] <= qual[i];
          M_LATCH: if (tick && qual[i]) act_q[i] <= 1'b1;
                   else if (clr) act_q[i] <= 1'b0;
          M_PULSE: if (tick)
          begin
            if (qual[i] && !qprev_q[i])
            begin
              act_q[i]  <= 1'b1;
              pcnt_q[i] <= 8'(cfg_q[i].pw * `PW_TICKS);
            end
            else if (pcnt_q[i] > 8'h01) pcnt_q[i] <= pcnt_q[i] - 8'h01;
            else
            begin
              act_q[i]  <= 1'b0;
              pcnt_q[i] <= '0;
            end
          end
          default: act_q[i] <= 1'b0;
        endcase
      end

  // Relay drive; the serial link error never reaches this block, so it cannot close a relay.
  logic err_any;
  assign err_any = meas_err || (|bad);
  logic [NCH-1:0] relay_d;
  always_comb
    for (int i = 0; i < NCH; i++)
      unique case (cfg_q[i].func)
        F_OK:    relay_d[i] = !err_any && !(|(act_q & ~(NCH'(1) << i)));
        F_ERROR: relay_d[i] = err_any;
        default: relay_d[i] = act_q[i];
      endcase
  always_ff @(posedge clk)
    if (rst) relay_q <= '0;
    else if (ce) relay_q <= relay_d;

  // Section measurement.
  logic                 below_q;
  logic [31:0]          sec_cnt_q;
  logic [15:0]          secs_q;
  logic [VAL_W+31:0]    sum_q;
  logic [31:0]          cnt_q;
  logic [VAL_W-1:0]     max_q, min_q;
  sect_stat_s           disp_q;
  logic                 go_run, end_run, sec_tick, hit;
  assign sec_tick = (st_q == S_RUN) && (sec_cnt_q == 32'(SEC_CYC - 1));
  assign hit      = below_q ? (meas_value >= thr_q) : (meas_value <= thr_q);
  assign go_run   = ctrl_q[`CTRL_SS] && ((st_q == S_IDLE && start_e && !ctrl_q[`CTRL_AUTO])
                    || (st_q == S_ARMED && !stop_e && hit));
  assign end_run  = st_q == S_RUN && (stop_e || !ctrl_q[`CTRL_SS]
                    || (ctrl_q[`CTRL_AUTO] && secs_q >= secs_lim_q));

  always_ff @(posedge clk)
    if (rst)
    begin
      st_q    <= S_IDLE;
      below_q <= 1'b0;
    end
    else if (ce)
      unique case (st_q)
        S_IDLE:
          if (ctrl_q[`CTRL_SS] && start_e)
          begin
            st_q    <= ctrl_q[`CTRL_AUTO] ? S_ARMED : S_RUN;
            below_q <= meas_value < thr_q;
          end
        S_ARMED:
          if (stop_e || !ctrl_q[`CTRL_SS]) st_q <= S_IDLE;
          else if (go_run) st_q <= S_RUN;
        S_RUN:
          if (end_run) st_q <= S_IDLE;
      endcase

  always_ff @(posedge clk)
    if (rst)
    begin
      sec_cnt_q <= '0;
      secs_q    <= '0;
    end
    else if (ce)
    begin
      if (go_run)
      begin
        sec_cnt_q <= '0;
        secs_q    <= '0;
      end
      else if (sec_tick)
      begin
        sec_cnt_q <= '0;
        secs_q    <= secs_q + 16'h0001;
      end
      else if (st_q == S_RUN) sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
    end

  // The divider is wide, but it only feeds the display refresh once per second and at section end.
  always_ff @(posedge clk)
    if (rst)
    begin
      sum_q  <= '0;
      cnt_q  <= '0;
      max_q  <= '0;
      min_q  <= '1;
      disp_q <= '0;
    end
    else if (ce)
    begin
      if (go_run)
      begin
        sum_q <= '0;
        cnt_q <= '0;
        max_q <= '0;
        min_q <= '1;
      end
      else if (st_q == S_RUN && meas_valid)
      begin
        sum_q <= sum_q + (VAL_W+32)'(meas_value);
        cnt_q <= cnt_q + 32'h0000_0001;
        if (meas_value > max_q) max_q <= meas_value;
        if (meas_value < min_q) min_q <= meas_value;
      end
      if (sec_tick || end_run)
      begin
        disp_q.avg <= (cnt_q == '0) ? '0 : VAL_W'(sum_q / cnt_q);
        disp_q.max <= max_q;
        disp_q.min <= min_q;
      end
    end

  // Displays and register reads.
  always_ff @(posedge clk)
    if (rst)
    begin
      main_disp_q <= '0;
      sub_disp_q  <= '0;
      ss_busy_q   <= 1'b0;
    end
    else if (ce)
    begin
      main_disp_q <= meas_value;
      ss_busy_q   <= st_q == S_RUN;
      if (!ctrl_q[`CTRL_2L]) sub_disp_q <= '0;
      else if (ctrl_q[`CTRL_SEL+1]) sub_disp_q <= disp_q.min;
      else if (ctrl_q[`CTRL_SEL]) sub_disp_q <= disp_q.max;
      else sub_disp_q <= disp_q.avg;
    end

  always_ff @(posedge clk)
    if (rst) rdata_q <= '0;
    else if (ce)
    begin
      rdata_q <= '0;
      if (rd)
      begin
        unique case (addr)
          `REG_CTRL: rdata_q <= 32'(ctrl_q);
          `REG_THR:  rdata_q <= 32'(thr_q);
          `REG_SECS: rdata_q <= 32'(secs_lim_q);
          `REG_STAT: rdata_q <= 32'({act_q, relay_q, err_any, st_q});
          `REG_AVG:  rdata_q <= 32'(disp_q.avg);
          `REG_MAX:  rdata_q <= 32'(disp_q.max);
          `REG_MIN:  rdata_q <= 32'(disp_q.min);
          default:   ;
        endcase
        for (int i = 0; i < NCH; i++)
        begin
          if (addr == 8'(`REG_CH + i * `CH_STRIDE)) rdata_q <= 32'(cfg_q[i]);
          if (addr == 8'(`REG_CH + i * `CH_STRIDE + `CH_LIMIT)) rdata_q <= 32'(lim_q[i]);
        end
      end
    end

  // Checks on the judgment channels and the section engine.
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ch_cfg_s c0;
  assign c0 = cfg_q[0];

  AST_AUTO_ON: assert property (ce && tick && c0.mode == M_AUTO && c0.func == F_UPPER
    && c0.dly == '0 && meas_value >= lim_q[0] |=> act_q[0])
    else $error("auto channel failed to turn on");
  AST_AUTO_OFF: assert property (ce && tick && c0.mode == M_AUTO && c0.func == F_UPPER
    && c0.hyst <= 0 && meas_value < lim_q[0] |=> !act_q[0])
    else $error("auto channel failed to turn off");
  AST_HYST: assert property (ce && tick && c0.mode == M_AUTO && c0.func == F_UPPER
    && act_q[0] && c0.hyst == `HYST_MAX && meas_value >= lim_q[0] - lim_q[0] / 5
    |=> act_q[0])
    else $error("hysteresis band released output");
  AST_LATCH_HOLD: assert property (act_q[1] && cfg_q[1].mode == M_LATCH && !clr
    ##1 cfg_q[1].mode == M_LATCH |-> act_q[1])
    else $error("latched output dropped");
  AST_LATCH_CLR: assert property (ce && act_q[1] && cfg_q[1].mode == M_LATCH && clr
    && !(tick && qual[1]) |=> !act_q[1])
    else $error("latched output not cleared");
  AST_SS_BLOCK: assert property (ce && ctrl_q[`CTRL_SS] && st_q != S_IDLE && act_q[1]
    && cfg_q[1].mode == M_LATCH |=> act_q[1]) else $error("reset accepted during section");
  AST_PULSE: assert property ($rose(act_q[2]) && cfg_q[2].mode == M_PULSE
    |-> pcnt_q[2] == cfg_q[2].pw)
    else $error("pulse width not loaded");
  AST_DELAY: assert property ($rose(act_q[0]) |-> $past(dcnt_q[0])
    >= need_ticks(c0.dly))
    else $error("output before delay elapsed");
  AST_ERR_RELAY: assert property (ce && cfg_q[2].func == F_ERROR
    |=> relay_q[2] == $past(err_any)) else $error("error relay mismatch");
  AST_ARMED: assert property (ce && st_q == S_ARMED && !go_run |=> $stable(cnt_q))
    else $error("accumulated while armed");
  AST_MAX: assert property (ce && st_q == S_RUN && meas_valid && !go_run
    |=> max_q >= $past(meas_value))
    else $error("maximum below a sample");

  COV_LATCH: cover property (cfg_q[1].mode == M_LATCH && $rose(act_q[1]));
  COV_PULSE: cover property (cfg_q[2].mode == M_PULSE && $fell(act_q[2]));
  COV_AUTO_SECT: cover property (st_q == S_ARMED ##1 st_q == S_RUN);
  COV_SECT_END: cover property (st_q == S_RUN ##1 st_q == S_IDLE);
endmodule

/* switch_panel.sv */
// Front-panel switch and external reset model that drives the judge's pins.
`timescale 1ns/1ps
module switch_panel
(
  // Clock.
  input  wire logic clk,
  // Switch and reset pins, idle low.
  output logic      start_sw,
  output logic      stop_sw,
  output logic      reset_sw,
  output logic      ext_reset
);
  initial
  begin
    start_sw  = 1'b0;
    stop_sw   = 1'b0;
    reset_sw  = 1'b0;
    ext_reset = 1'b0;
  end
  // A press is held four cycles so it survives the two-stage synchroniser.
  task automatic press(input int which);
    @(posedge clk);
    case (which)
      0: start_sw <= 1'b1;
      1: stop_sw <= 1'b1;
      2: reset_sw <= 1'b1;
      default: ext_reset <= 1'b1;
    endcase
    repeat (4) @(posedge clk);
    {start_sw, stop_sw, reset_sw, ext_reset} <= 4'h0;
    repeat (4) @(posedge clk);
  endtask
endmodule

/* tb_speed_limit_judge.sv */
// Self-checking testbench of the speed limit judge.
`timescale 1ns/1ps
`include "speed_judge_defs.svh"
module tb_speed_limit_judge;
  import speed_judge_pkg::*;
  // Short tick and second keep the run brief; all expectations use these.
  localparam int TK = 20;
  localparam int SC = 200;
  logic        clk;
  logic        rst;
  logic        ce;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata_q;
  logic [19:0] meas_value;
  logic        meas_valid;
  logic        meas_err;
  logic        start_sw;
  logic        stop_sw;
  logic        reset_sw;
  logic        ext_reset;
  logic [2:0]  relay_q;
  logic [19:0] main_disp_q;
  logic [19:0] sub_disp_q;
  logic        ss_busy_q;
  int          fails;
  int          n_checks;
  int          k;
  int          n;

  speed_limit_judge #(.TICK_CYC(TK), .SEC_CYC(SC)) uut
  (
    .clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .meas_value(meas_value), .meas_valid(meas_valid),
    .meas_err(meas_err), .start_sw(start_sw), .stop_sw(stop_sw), .reset_sw(reset_sw),
    .ext_reset(ext_reset), .relay_q(relay_q), .main_disp_q(main_disp_q),
    .sub_disp_q(sub_disp_q), .ss_busy_q(ss_busy_q)
  );

  switch_panel pnl
  (
    .clk(clk), .start_sw(start_sw), .stop_sw(stop_sw), .reset_sw(reset_sw),
    .ext_reset(ext_reset)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rl(input logic [2:0] e);
    chk("relay_q", {29'h0000_0000, e}, {29'h0000_0000, relay_q});
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // The read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk("rdata_q", e, rdata_q & m);
  endtask

  task automatic setv(input logic [19:0] v);
    @(posedge clk);
    meas_value <= v;
  endtask

  task automatic sample(input logic [19:0] v);
    @(posedge clk);
    meas_value <= v;
    meas_valid <= 1'b1;
    @(posedge clk);
    meas_valid <= 1'b0;
  endtask

  task automatic ticks(input int t);
    repeat (t * TK + 2) @(posedge clk);
    #1;
  endtask

  function automatic logic [31:0] cfg(func_e f, mode_e m, logic [5:0] h, logic [7:0] p,
                                      logic [4:0] d);
    return {9'h000, f, m, h, p, d};
  endfunction

  initial
  begin
    #200_000;
    fails++;
    wrap_up();
  end

  initial
  begin
    {rst, ce, wr, rd, meas_valid, meas_err} = 6'h30;
    {addr, wdata} = 40'h00_0000_0000;
    meas_value = 20'h0_02bc;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    rl(3'h0);
    rd_reg(8'h24, 32'hffff_ffff, 32'h0000_0000);
    wr_reg(8'h1c, 32'h0000_1234);
    rd_reg(8'h1c, 32'hffff_ffff, 32'h0000_0000);
    wr_reg(8'h20, cfg(F_UPPER, M_AUTO, 6'h14, 8'h00, 5'h00));
    wr_reg(8'h24, 32'h0000_03e8);
    wr_reg(8'h30, cfg(F_LOWER, M_LATCH, 6'h00, 8'h00, 5'h00));
    wr_reg(8'h34, 32'h0000_01f4);
    wr_reg(8'h40, cfg(F_OK, M_AUTO, 6'h00, 8'h00, 5'h00));
    rd_reg(8'h24, 32'hffff_ffff, 32'h0000_03e8);
    ticks(2);
    rl(3'h4);
    setv(20'h0_03e8);
    ticks(2);
    rl(3'h1);
    setv(20'h0_0352);
    ticks(2);
    rl(3'h1);
    setv(20'h0_031f);
    ticks(2);
    rl(3'h4);
    for (int i = 2; i < 4; i++)
    begin
      setv(20'h0_0190);
      ticks(2);
      rl(3'h2);
      setv(20'h0_02bc);
      ticks(2);
      rl(3'h2);
      pnl.press(i);
      ticks(2);
      rl(3'h4);
    end
    wr_reg(8'h40, cfg(F_ERROR, M_AUTO, 6'h00, 8'h00, 5'h00));
    meas_err <= 1'b1;
    ticks(2);
    chk("relay_q2", 32'h0000_0001, {31'h0000_0000, relay_q[2]});
    @(posedge clk);
    meas_err <= 1'b0;
    ticks(2);
    chk("relay_q2", 32'h0000_0000, {31'h0000_0000, relay_q[2]});
    wr_reg(8'h40, cfg(F_ERROR, mode_e'(2'h3), 6'h00, 8'h00, 5'h00));
    ticks(2);
    chk("relay_q2", 32'h0000_0001, {31'h0000_0000, relay_q[2]});
    rd_reg(`REG_STAT, 32'h0000_0004, 32'h0000_0004);
    wr_reg(8'h44, 32'h0000_03e8);
    wr_reg(8'h40, cfg(F_UPPER, M_PULSE, 6'h00, 8'h03, 5'h00));
    ticks(2);
    setv(20'h0_03e8);
    k = 0;
    n = 0;
    while (relay_q[2] !== 1'b1 && k < 100)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (relay_q[2] === 1'b1 && n < 200)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("pulse_len", 3 * TK, n);
    ticks(2);
    chk("relay_q2", 32'h0000_0000, {31'h0000_0000, relay_q[2]});
    setv(20'h0_02bc);
    wr_reg(8'h20, cfg(F_UPPER, M_AUTO, 6'h00, 8'h00, 5'h01));
    ticks(2);
    setv(20'h0_03e8);
    ticks(3);
    setv(20'h0_02bc);
    ticks(1);
    setv(20'h0_03e8);
    ticks(3);
    chk("relay_q0", 32'h0000_0000, {31'h0000_0000, relay_q[0]});
    ticks(3);
    chk("relay_q0", 32'h0000_0001, {31'h0000_0000, relay_q[0]});
    setv(20'h0_0190);
    ticks(2);
    setv(20'h0_02bc);
    wr_reg(`REG_CTRL, 32'h0000_000d);
    pnl.press(0);
    repeat (4) @(posedge clk);
    #1;
    chk("ss_busy_q", 32'h0000_0001, {31'h0000_0000, ss_busy_q});
    pnl.press(2);
    ticks(2);
    chk("relay_q1", 32'h0000_0001, {31'h0000_0000, relay_q[1]});
    sample(20'h0_000a);
    sample(20'h0_001e);
    sample(20'h0_0014);
    pnl.press(1);
    repeat (4) @(posedge clk);
    sample(20'h0_0063);
    setv(20'h0_0014);
    repeat (4) @(posedge clk);
    rd_reg(`REG_STAT, 32'h0000_0003, 32'h0000_0000);
    rd_reg(`REG_AVG, 32'h000f_ffff, 32'h0000_0014);
    rd_reg(`REG_MAX, 32'h000f_ffff, 32'h0000_001e);
    rd_reg(`REG_MIN, 32'h000f_ffff, 32'h0000_000a);
    chk("sub_disp_q", 32'h0000_001e, {12'h000, sub_disp_q});
    chk("main_disp_q", 32'h0000_0014, {12'h000, main_disp_q});
    setv(20'h0_02bc);
    pnl.press(2);
    ticks(2);
    chk("relay_q1", 32'h0000_0000, {31'h0000_0000, relay_q[1]});
    wr_reg(`REG_THR, 32'h0000_07d0);
    wr_reg(`REG_SECS, 32'h0000_0001);
    wr_reg(`REG_CTRL, 32'h0000_0003);
    setv(20'h0_09c4);
    pnl.press(0);
    repeat (4) @(posedge clk);
    rd_reg(`REG_STAT, 32'h0000_0003, 32'h0000_0001);
    chk("sub_disp_q", 32'h0000_0000, {12'h000, sub_disp_q});
    setv(20'h0_07d0);
    repeat (6) @(posedge clk);
    rd_reg(`REG_STAT, 32'h0000_0003, 32'h0000_0002);
    repeat (SC + 20) @(posedge clk);
    rd_reg(`REG_STAT, 32'h0000_0003, 32'h0000_0000);
    wrap_up();
  end
endmodule
